// file: rtl/pims_top.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
module pims_top (
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  hsel_i,
    input  wire logic [31:0]           haddr_i,
    input  wire logic [1:0]            htrans_i,
    input  wire logic                  hwrite_i,
    input  wire logic [2:0]            hsize_i,
    input  wire logic [31:0]           hwdata_i,
    input  wire logic                  hready_i,
    input  wire pims_pkg::pims_events_t events_i,
    output logic      [31:0]           hrdata_o,
    output logic                       hreadyout_o,
    output logic                       hresp_o,
    output logic                       irq_n_o
);

    function automatic logic addr_hit(input logic [31:0] addr, input logic [11:0] target);
        return addr[31:2] == {20'h00000, target[11:2]};
    endfunction : addr_hit

    logic [15:0]            mask;
    logic [15:0]            status;
    logic [15:0]            cfg;
    logic                   wr_pend;
    logic [31:0]            wr_addr;
    pims_pkg::pims_events_t ev_prev;

    // Bus decode
    wire         access_take = hsel_i & htrans_i[1] & hready_i;
    wire         rd_take     = access_take & ~hwrite_i;
    wire         wr_take     = access_take & hwrite_i;
    wire         rd_mask     = rd_take & addr_hit(haddr_i, pims_pkg::MASK_ADDR);
    wire         rd_status   = rd_take & addr_hit(haddr_i, pims_pkg::STATUS_ADDR);
    wire         rd_cfg      = rd_take & addr_hit(haddr_i, pims_pkg::CFG_ADDR);
    wire         wr_mask     = wr_pend & addr_hit(wr_addr, pims_pkg::MASK_ADDR);
    wire         wr_cfg      = wr_pend & addr_hit(wr_addr, pims_pkg::CFG_ADDR);

    // Configuration and compatibility mode
    wire  [15:0] next_cfg    = wr_cfg ? (hwdata_i[15:0] & 16'h0001) : cfg;
    wire         compat      = cfg[pims_pkg::CFG_COMPAT_BIT];
    wire         next_compat = next_cfg[pims_pkg::CFG_COMPAT_BIT];

    // Mask register; writes dropped while in compatibility mode
    wire         mask_wr_ok  = wr_mask & ~compat;
    wire  [15:0] next_mask   = mask_wr_ok ? (hwdata_i[15:0] & pims_pkg::MASK_WRITABLE)
                                          : mask;
    wire  [15:0] eff_mask      = compat ? 16'h0000 : mask;
    wire  [15:0] next_eff_mask = next_compat ? 16'h0000 : next_mask;

    // Event detection
    wire  [15:0] ev_set;
    assign ev_set[pims_pkg::BIT_CARRIER_MON]   = events_i.carrier_integrity_monitor;
    assign ev_set[pims_pkg::BIT_LINK_CHANGE]   = events_i.link_up ^ ev_prev.link_up;
    assign ev_set[pims_pkg::BIT_DESCR_CHANGE]  = events_i.descr_locked ^ ev_prev.descr_locked;
    assign ev_set[pims_pkg::BIT_PREMATURE_END] = events_i.premature_end & events_i.speed_100;
    assign ev_set[pims_pkg::BIT_DISC_MSB]      = events_i.disc_cnt_msb & ~ev_prev.disc_cnt_msb;
    assign ev_set[pims_pkg::BIT_FCAR_MSB]      = events_i.fcar_cnt_msb & ~ev_prev.fcar_cnt_msb;
    assign ev_set[pims_pkg::BIT_RXERR_MSB]     = events_i.rxerr_cnt_msb & ~ev_prev.rxerr_cnt_msb;
    assign ev_set[pims_pkg::BIT_LOOPBACK_FLT]  = events_i.elastic_fault & events_i.remote_loopback;
    assign ev_set[pims_pkg::BIT_RESET_DONE]    = events_i.reset_done & ~ev_prev.reset_done;
    assign ev_set[pims_pkg::BIT_JABBER]        = events_i.jabber;
    assign ev_set[pims_pkg::BIT_AN_COMPLETE]   = events_i.an_complete & ~ev_prev.an_complete;
    assign ev_set[pims_pkg::BIT_PD_FAULT]      = events_i.pd_fault;
    assign ev_set[pims_pkg::BIT_PD_FAIL]       = events_i.pd_fail;
    assign ev_set[pims_pkg::BIT_REMOTE_FAULT]  = events_i.an_remote_fault | events_i.far_end_fault;
    assign ev_set[pims_pkg::BIT_PAGE_RX]       = events_i.page_rx;
    assign ev_set[pims_pkg::BIT_RESERVED]      = 1'b0;

    // Status: read clears, a simultaneous event still sets
    wire  [15:0] status_kept = rd_status ? 16'h0000 : status;
    wire  [15:0] next_status = status_kept | ev_set;

    // Interrupt follows status gated by mask
    wire         next_irq_n  = ~|(next_status & next_eff_mask);

    // Read data, captured in the address phase
    wire  [31:0] next_rdata  = rd_mask   ? {16'h0000, next_eff_mask} :
                               rd_status ? {16'h0000, status}        :
                               rd_cfg    ? {16'h0000, next_cfg}      :
                               rd_take   ? 32'h0000_0000             : hrdata_o;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            mask <= pims_pkg::MASK_RESET;
        end else begin
            mask <= next_mask;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            status <= pims_pkg::STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cfg <= pims_pkg::CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            irq_n_o <= 1'b1;
        end else begin
            irq_n_o <= next_irq_n;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ev_prev <= '0;
        end else begin
            ev_prev <= events_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
        end else begin
            wr_pend <= wr_take;
            wr_addr <= wr_take ? haddr_i : wr_addr;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            hrdata_o <= pims_pkg::RDATA_RESET;
        end else begin
            hrdata_o <= next_rdata;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // Checks

    a_irq_follows_status: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ##1 (irq_n_o == ~|($past(next_status) & $past(next_eff_mask))) &&
            (irq_n_o == ~|(status & eff_mask)))
        else $error("Interrupt output does not match masked status");

    a_masked_event_quiet: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (status == 16'h0000 && !rd_status && ev_set != 16'h0000 &&
         (ev_set & next_eff_mask) == 16'h0000)
        |=> irq_n_o && (status == $past(ev_set)))
        else $error("Masked event disturbed interrupt or was not recorded");

    a_enabled_event_fires: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ((ev_set & next_eff_mask) != 16'h0000) |=> !irq_n_o)
        else $error("Enabled event did not assert the interrupt");

    a_mask_reset_value: assert property (
        @(posedge core_clk_i)
        !reset_n_i |=> (mask == pims_pkg::MASK_RESET) && irq_n_o && (status == pims_pkg::STATUS_RESET))
        else $error("Mask or status wrong after reset");

    a_reserved_bit_zero: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !mask[0] && !status[0])
        else $error("Reserved bit became set");

    a_compat_blocks_wr: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (compat && wr_mask) |=> $stable(mask))
        else $error("Mask written in compatibility mode");

    a_compat_no_irq: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (compat && next_compat) |=> irq_n_o)
        else $error("Interrupt asserted in compatibility mode");

    a_read_clears_all: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        rd_status |=> (status == $past(ev_set)) &&
                      (hrdata_o[15:0] == $past(status)))
        else $error("Status read did not clear or lost an event");

    a_link_change_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (events_i.link_up != $past(events_i.link_up)) |=> status[14])
        else $error("Link change not recorded");

    a_counter_msb_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        $rose(events_i.disc_cnt_msb) or $rose(events_i.fcar_cnt_msb) or
        $rose(events_i.rxerr_cnt_msb)
        |=> status[11] || status[10] || status[9])
        else $error("Counter warning not recorded");

    a_premature_speed: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (status[12] == 1'b0 && events_i.premature_end && !events_i.speed_100)
        |=> !status[12])
        else $error("Premature end recorded outside 100 Mb/s");

    a_status_sticky: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (status[15] && !rd_status) |=> status[15] [*1] ##0
        ((status[13] == 1'b0) || $past(status[13]) || $past(ev_set[13])))
        else $error("Status bit dropped without a read");

    a_bus_always_okay: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        hreadyout_o && !hresp_o)
        else $error("Slave stalled or answered with an error");

    a_carrier_sets_status: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        events_i.carrier_integrity_monitor |=> status[15])
        else $error("Unstable link event not recorded");

    a_descr_sets_status: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $changed(events_i.descr_locked)) |=> status[13])
        else $error("Descrambler lock change not recorded");

    a_premature_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (events_i.premature_end && events_i.speed_100) |=> status[12])
        else $error("Premature end not recorded");

    a_disc_msb_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $rose(events_i.disc_cnt_msb)) |=> status[11])
        else $error("Disconnect counter warning not recorded");

    a_fcar_msb_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $rose(events_i.fcar_cnt_msb)) |=> status[10])
        else $error("False carrier counter warning not recorded");

    a_rxerr_msb_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $rose(events_i.rxerr_cnt_msb)) |=> status[9])
        else $error("Receive error counter warning not recorded");

    a_loopback_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (events_i.elastic_fault && events_i.remote_loopback) |=> status[8])
        else $error("Loopback buffer fault not recorded");

    a_loopback_needs_mode: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (!status[8] && events_i.elastic_fault && !events_i.remote_loopback) |=> !status[8])
        else $error("Buffer fault recorded outside remote loopback");

    a_reset_done_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $rose(events_i.reset_done)) |=> status[7])
        else $error("Reset completion not recorded");

    a_jabber_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        events_i.jabber |=> status[6])
        else $error("Jabber not recorded");

    a_an_done_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $rose(events_i.an_complete)) |=> status[5])
        else $error("Negotiation completion not recorded");

    a_pd_fault_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        events_i.pd_fault |=> status[4])
        else $error("Unstable legacy signalling not recorded");

    a_pd_fail_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        events_i.pd_fail |=> status[3])
        else $error("Unadvertised parallel detect not recorded");

    a_remote_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (events_i.an_remote_fault || events_i.far_end_fault) |=> status[2])
        else $error("Remote fault not recorded");

    a_page_sets: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        events_i.page_rx |=> status[1])
        else $error("Received page not recorded");

    a_no_silent_clear: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !rd_status |=> (($past(status) & ~status) == 16'h0000))
        else $error("Status bit cleared without a read");

    a_rdata_upper_zero: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        hrdata_o[31:16] == 16'h0000)
        else $error("Upper read data bits not zero");

    a_mask_write_lands: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (wr_mask && !compat)
        |=> (mask == ($past(hwdata_i[15:0]) & pims_pkg::MASK_WRITABLE)))
        else $error("Mask write did not land");

    a_compat_reads_zero: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (rd_mask && next_compat) |=> (hrdata_o == 32'h0000_0000))
        else $error("Mask visible in compatibility mode");

    a_link_irq_enabled: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $changed(events_i.link_up) && mask[14] && !compat && !wr_mask && !wr_cfg)
        |=> !irq_n_o)
        else $error("Enabled link change did not interrupt");

    a_reset_done_irq: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $rose(events_i.reset_done) && mask[7] && !compat && !wr_mask && !wr_cfg)
        |=> !irq_n_o)
        else $error("Enabled reset completion did not interrupt");

    a_disc_irq: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        ($past(reset_n_i) && $rose(events_i.disc_cnt_msb) && mask[11] && !compat && !wr_mask && !wr_cfg)
        |=> !irq_n_o)
        else $error("Enabled disconnect warning did not interrupt");

    a_irq_release: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (rd_status && ev_set == 16'h0000) |=> irq_n_o)
        else $error("Interrupt not released by the clearing read");

    a_irq_has_cause: assert property (
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !irq_n_o |-> (((status & mask) != 16'h0000) && !compat))
        else $error("Interrupt asserted without an enabled status bit");

endmodule : pims_top

// file: rtl/pims_pkg.sv
package pims_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0]  MASK_IDX       = 8'h10;
    localparam logic [7:0]  STATUS_IDX     = 8'h11;
    localparam logic [7:0]  CFG_IDX        = 8'h1C;
    localparam logic [11:0] MASK_ADDR      = {2'h0, MASK_IDX, 2'h0};
    localparam logic [11:0] STATUS_ADDR    = {2'h0, STATUS_IDX, 2'h0};
    localparam logic [11:0] CFG_ADDR       = {2'h0, CFG_IDX, 2'h0};

    // Bit positions shared by mask and status
    localparam int BIT_CARRIER_MON   = 15;
    localparam int BIT_LINK_CHANGE   = 14;
    localparam int BIT_DESCR_CHANGE  = 13;
    localparam int BIT_PREMATURE_END = 12;
    localparam int BIT_DISC_MSB      = 11;
    localparam int BIT_FCAR_MSB      = 10;
    localparam int BIT_RXERR_MSB     = 9;
    localparam int BIT_LOOPBACK_FLT  = 8;
    localparam int BIT_RESET_DONE    = 7;
    localparam int BIT_JABBER        = 6;
    localparam int BIT_AN_COMPLETE   = 5;
    localparam int BIT_PD_FAULT      = 4;
    localparam int BIT_PD_FAIL       = 3;
    localparam int BIT_REMOTE_FAULT  = 2;
    localparam int BIT_PAGE_RX       = 1;
    localparam int BIT_RESERVED      = 0;

    // Configuration register field
    localparam int CFG_COMPAT_BIT = 0;

    // Values after reset, and the writable mask bits
    localparam logic [15:0] MASK_RESET     = 16'h4080;
    localparam logic [15:0] MASK_WRITABLE  = 16'hFFFE;
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
    localparam logic [15:0] CFG_RESET      = 16'h0000;
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

    // Event sources, all on the core clock
    typedef struct packed {
        logic carrier_integrity_monitor; // Pulse, unstable link seen
        logic link_up;           // Level
        logic descr_locked;      // Level
        logic speed_100;         // Level
        logic premature_end;     // Pulse
        logic disc_cnt_msb;      // Level
        logic fcar_cnt_msb;      // Level
        logic rxerr_cnt_msb;     // Level
        logic remote_loopback;   // Level
        logic elastic_fault;     // Pulse
        logic reset_done;        // Level
        logic jabber;            // Pulse
        logic an_complete;       // Level
        logic pd_fault;          // Pulse
        logic pd_fail;           // Pulse
        logic an_remote_fault;   // Pulse
        logic far_end_fault;     // Pulse
        logic page_rx;           // Pulse
    } pims_events_t;

endpackage : pims_pkg

// file: tb/tb_pims_top.sv
`timescale 1ns/10ps
module tb_pims_top;
    logic                   core_clk_i;
    logic                   reset_n_i;
    logic                   hsel_i;
    logic [31:0]            haddr_i;
    logic [1:0]             htrans_i;
    logic                   hwrite_i;
    logic [31:0]            hwdata_i;
    pims_pkg::pims_events_t events_i;
    logic [31:0]            hrdata_o;
    logic                   hreadyout_o;
    logic                   hresp_o;
    logic                   irq_n_o;
    int                     errors;
    int                     checks;
    logic [31:0]            rd;
    logic [31:0]            mask_a;
    logic [31:0]            stat_a;
    logic [31:0]            cfg_a;
    // Event vector driven for one cycle and the status it must leave behind
    logic [17:0]            ev_tab [0:17] = '{18'h20000, 18'h10000, 18'h08000, 18'h06000, 18'h02000, 18'h01000,
        18'h00800, 18'h00400, 18'h00300, 18'h00100, 18'h00080, 18'h00040, 18'h00020, 18'h00010, 18'h00008,
        18'h00004, 18'h00002, 18'h00001};
    logic [15:0]            exp_tab [0:17] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0000, 16'h0800,
        16'h0400, 16'h0200, 16'h0100, 16'h0000, 16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008,
        16'h0004, 16'h0004, 16'h0002};

    pims_top u_pims_top (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hsize_i     (3'h2),
        .hwdata_i    (hwdata_i),
        .hready_i    (hreadyout_o),
        .events_i    (events_i),
        .hrdata_o    (hrdata_o),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o),
        .irq_n_o     (irq_n_o)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic wrap_up;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge core_clk_i);
        while (hreadyout_o !== 1'b1 && n < 20) begin
            n++;
            @(posedge core_clk_i);
        end
        if (hreadyout_o !== 1'b1) begin
            errors++;
            wrap_up();
        end
    endtask : wait_ready

    // One single transfer; ev is driven during the address phase only
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, input logic [17:0] ev,
                       output logic [31:0] data);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i  <= a;
        hwrite_i <= w;
        events_i <= ev;
        wait_ready();
        htrans_i <= 2'h0;
        hsel_i   <= 1'b0;
        hwdata_i <= wd;
        events_i <= '0;
        wait_ready();
        data = hrdata_o;
    endtask : bus

    task automatic pulse(input logic [17:0] ev);
        events_i <= ev;
        @(posedge core_clk_i);
        events_i <= '0;
        @(posedge core_clk_i);
    endtask : pulse

    initial begin
        errors = 0;
        checks = 0;
        mask_a = {20'h0, pims_pkg::MASK_ADDR};
        stat_a = {20'h0, pims_pkg::STATUS_ADDR};
        cfg_a  = {20'h0, pims_pkg::CFG_ADDR};
        reset_n_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hwdata_i = 32'h0;
        events_i = '0;
        repeat (6) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        chk({31'h0, irq_n_o}, 32'h1);
        bus(1'b0, mask_a, 32'h0, 18'h0, rd);
        chk(rd, 32'h0000_4080);
        bus(1'b0, stat_a, 32'h0, 18'h0, rd);
        chk(rd, 32'h0);
        bus(1'b1, mask_a, 32'hFFFF_FFFF, 18'h0, rd);
        bus(1'b0, mask_a, 32'h0, 18'h0, rd);
        chk(rd, 32'h0000_FFFE);
        for (int i = 0; i < 18; i++) begin
            pulse(ev_tab[i]);
            chk({31'h0, irq_n_o}, {31'h0, exp_tab[i] == 16'h0});
            bus(1'b0, stat_a, 32'h0, 18'h0, rd);
            chk(rd, {16'h0, exp_tab[i]});
            chk({31'h0, irq_n_o}, 32'h1);
        end
        bus(1'b1, mask_a, 32'h0000_0040, 18'h0, rd);
        pulse(18'h00001);
        chk({31'h0, irq_n_o}, 32'h1);
        bus(1'b0, stat_a, 32'h0, 18'h0, rd);
        chk(rd, 32'h0000_0002);
        bus(1'b1, cfg_a, 32'h1, 18'h0, rd);
        bus(1'b0, cfg_a, 32'h0, 18'h0, rd);
        chk(rd, 32'h1);
        bus(1'b1, mask_a, 32'hFFFF_FFFF, 18'h0, rd);
        bus(1'b0, mask_a, 32'h0, 18'h0, rd);
        chk(rd, 32'h0);
        pulse(18'h00040);
        chk({31'h0, irq_n_o}, 32'h1);
        bus(1'b1, cfg_a, 32'h0, 18'h0, rd);
        bus(1'b0, mask_a, 32'h0, 18'h0, rd);
        chk(rd, 32'h0000_0040);
        chk({31'h0, irq_n_o}, 32'h0);
        bus(1'b0, stat_a, 32'h0, 18'h00040, rd);
        chk(rd, 32'h0000_0040);
        chk({31'h0, irq_n_o}, 32'h0);
        bus(1'b0, stat_a, 32'h0, 18'h0, rd);
        chk(rd, 32'h0000_0040);
        bus(1'b1, stat_a, 32'hFFFF_FFFF, 18'h0, rd);
        bus(1'b0, stat_a, 32'h0, 18'h0, rd);
        chk(rd, 32'h0);
        chk({31'h0, irq_n_o}, 32'h1);
        bus(1'b0, 32'h0, 32'h0, 18'h0, rd);
        chk(rd, 32'h0);
        chk({31'h0, hresp_o}, 32'h0);
        chk({31'h0, hreadyout_o}, 32'h1);
        wrap_up();
    end
endmodule : tb_pims_top
